// >>> design/smd_pkg.sv
// Constants and types shared by the supply monitor and diagnostics block.
package smd_pkg;

  // ---------------------------------------------------------------------------
  // Widths and clock
  // ---------------------------------------------------------------------------
  localparam int SMD_ADDR_W       = 7;
  localparam int SMD_DATA_W       = 8;
  localparam int SMD_CNT_W        = 16;
  localparam int SMD_CLK_PERIOD_NS = 5;

  // ---------------------------------------------------------------------------
  // Register addresses
  // ---------------------------------------------------------------------------
  localparam logic [6:0] SMD_ADDR_GATE_SETTING = 7'h15;
  localparam logic [6:0] SMD_ADDR_OVER_THR     = 7'h1A;
  localparam logic [6:0] SMD_ADDR_UNDER_THR    = 7'h1B;
  localparam logic [6:0] SMD_ADDR_SUPPLY_READ  = 7'h45;
  localparam logic [6:0] SMD_ADDR_TEMP_READ    = 7'h46;
  localparam logic [6:0] SMD_ADDR_DIAG         = 7'h7F;

  // ---------------------------------------------------------------------------
  // Gate supply setting range (target is (255 - code) * 62 mV)
  // ---------------------------------------------------------------------------
  localparam int         SMD_GATE_STEP_MV = 62;
  localparam logic [7:0] SMD_GATE_CODE_MAX_V = 8'h5D;
  localparam logic [7:0] SMD_GATE_CODE_MIN_V = 8'hB7;

  // ---------------------------------------------------------------------------
  // Diagnostic status bit positions
  // ---------------------------------------------------------------------------
  localparam int SMD_DG_REGULATED = 7;
  localparam int SMD_DG_RESERVED  = 6;
  localparam int SMD_DG_GATE_GOOD = 5;
  localparam int SMD_DG_OVERTEMP  = 4;
  localparam int SMD_DG_UNDER     = 3;
  localparam int SMD_DG_OVER      = 2;
  localparam int SMD_DG_CMD_ERR   = 1;
  localparam int SMD_DG_GATE_FLT  = 0;

  // ---------------------------------------------------------------------------
  // Reset values
  // ---------------------------------------------------------------------------
  localparam logic [7:0] SMD_RST_GATE_CODE = 8'h9A;
  localparam logic [7:0] SMD_RST_OVER_THR  = 8'hFF;
  localparam logic [7:0] SMD_RST_UNDER_THR = 8'h00;
  localparam logic [7:0] SMD_RST_READING   = 8'h00;

  // ---------------------------------------------------------------------------
  // Timing: times in ns, counts derived from the clock period
  // ---------------------------------------------------------------------------
  localparam int SMD_GATE_STARTUP_NS = 50000;
  localparam int SMD_GATE_ERR_NS     = 200000;
  localparam int SMD_FILTER_NS       = 10000;
  localparam int SMD_GATE_STARTUP_CYC =
    (SMD_GATE_STARTUP_NS + SMD_CLK_PERIOD_NS - 1) / SMD_CLK_PERIOD_NS;
  localparam int SMD_GATE_ERR_CYC     = SMD_GATE_ERR_NS / SMD_CLK_PERIOD_NS;
  localparam int SMD_FILTER_CYC       =
    (SMD_FILTER_NS + SMD_CLK_PERIOD_NS - 1) / SMD_CLK_PERIOD_NS;

  // ---------------------------------------------------------------------------
  // Gate supply sequencing states
  // ---------------------------------------------------------------------------
  typedef enum logic [1:0] {
    SMD_GS_IDLE,
    SMD_GS_START,
    SMD_GS_RUN
  } smd_gs_e;

endpackage

// >>> design/smd_filter.sv
// Symmetric level filter that follows its input only after a settled interval.
`timescale 1ns/10ps
module smd_filter #(
  parameter logic [15:0] FILT_CYC = 16'(smd_pkg::SMD_FILTER_CYC)
) (
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic level_in,
  output wire logic level_out
);
  import smd_pkg::*;

  typedef struct packed {
    logic                 out;
    logic [SMD_CNT_W-1:0] cnt;
  } smd_filt_s;

  smd_filt_s st;
  smd_filt_s next_st;

  // ---------------------------------------------------------------------------
  // Filter
  // ---------------------------------------------------------------------------
  // The output moves only when the input has differed for more than FILT_CYC
  // cycles, so a glitch never reaches the flag in either direction.
  always_comb begin
    next_st = st;
    if (level_in == st.out) begin
      next_st.cnt = '0;
    end else if (st.cnt == FILT_CYC) begin
      next_st.out = level_in;  // [RL15]
      next_st.cnt = '0;
    end else begin
      next_st.cnt = st.cnt + 16'h0001;
    end
  end

  // Register the state.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign level_out = st.out;

  // Output flips only after the input differed for the full interval.
  filter_hold_a : assert property (@(posedge clk) disable iff (!rst_n)  // [RL15]
    $changed(st.out) |-> $past(st.cnt) == FILT_CYC && $past(level_in) == st.out)
    else $error("regulated flag changed before the filter time");

endmodule

// >>> design/smd_monitor.sv
// Supply monitor, gate supply sequencing and diagnostic status register.
`timescale 1ns/10ps
// Functional notes
// [RL1] Hold 8-bit gate supply code; target (255-code)*62 mV, 0x5D..0xB7 permitted; here any code is stored without a command error.
// [RL2] Software reads the gate code back right after writing it.
// [RL3] Measure supply only while output enabled and gate supply good; 0.3606 V/step.
// [RL4] Supply below under threshold sets under flag and enters fail-silent.
// [RL5] Supply above over threshold sets over flag and enters fail-silent.
// [RL6] Junction temperature is a read-only 8-bit code.
// [RL7] Status byte: regulated 7, zero 6, good 5, temp 4, under 3, over 2, cmd 1, fault 0.
// [RL8] Status write or Off mode clears the five error flags.
// [RL9] Clearing a flag never releases fail-silent.
// [RL10] Every command is checked; disallowed ones set the command error flag.
// [RL11] Overtemperature sets its flag and enters fail-silent.
// [RL12] Software clears the status register before first evaluating it.
// [RL13] Gate supply missing its window by the error time sets fault, fail-silent.
// [RL14] Gate switching only while gate good; window loss clears it, fail-silent.
// [RL15] Regulated flag follows the output window after a filter time.
// [RL16] Status byte is returned in the upper byte of every response; here the first after reset or Off mode reads as zero.
// [RL17] Fail-silent is a latch released only by Off mode.
// [RL18] Under and over checks run only while the measurement is valid.
module smd_monitor #(
  parameter logic [15:0] GATE_STARTUP_CYC = 16'(smd_pkg::SMD_GATE_STARTUP_CYC),
  parameter logic [15:0] GATE_ERR_CYC     = 16'(smd_pkg::SMD_GATE_ERR_CYC),
  parameter logic [15:0] FILTER_CYC       = 16'(smd_pkg::SMD_FILTER_CYC)
) (
  input  wire logic                          clk,
  input  wire logic                          rst_n,
  input  wire logic                          off_mode,
  input  wire logic                          output_enable,
  input  wire logic                          cmd_valid,
  input  wire logic                          cmd_read,
  input  wire logic [smd_pkg::SMD_ADDR_W-1:0] cmd_addr,
  input  wire logic [smd_pkg::SMD_DATA_W-1:0] cmd_wdata,
  input  wire logic                          cmd_len_ok,
  output wire logic [smd_pkg::SMD_DATA_W-1:0] rsp_status,
  output wire logic [smd_pkg::SMD_DATA_W-1:0] rsp_data,
  input  wire logic                          supply_sample_valid,
  input  wire logic [smd_pkg::SMD_DATA_W-1:0] supply_sample,
  input  wire logic                          temp_sample_valid,
  input  wire logic [smd_pkg::SMD_DATA_W-1:0] temp_sample,
  input  wire logic                          temp_over_max,
  input  wire logic                          gate_supply_in_window,
  input  wire logic                          output_in_window,
  output wire logic [smd_pkg::SMD_DATA_W-1:0] gate_supply_code,
  output wire logic                          gate_switch_enable,
  output wire logic                          fail_silent
);
  import smd_pkg::*;

  // ---------------------------------------------------------------------------
  // State
  // ---------------------------------------------------------------------------
  typedef struct packed {
    logic [7:0]           gate_code;
    logic [7:0]           over_thr;
    logic [7:0]           under_thr;
    logic [7:0]           supply_rd;
    logic [7:0]           temp_rd;
    logic                 under_f;
    logic                 over_f;
    logic                 cmd_f;
    logic                 temp_f;
    logic                 gfault_f;
    logic                 good_f;
    logic                 fail;
    logic                 first;
    smd_gs_e              gst;
    logic [SMD_CNT_W-1:0] cnt;
    logic [7:0]           rsp;
  } smd_state_s;

  smd_state_s st;
  smd_state_s next_st;
  logic       regulated;
  logic [7:0] diag;
  logic       meas_valid;
  logic       hit_rw;
  logic       hit_ro;
  logic       hit_diag;
  logic       cmd_bad;
  logic       do_write;
  logic [7:0] rd_val;
  logic [4:0] set_v;
  logic [4:0] clr_v;
  logic [4:0] flags_v;

  // ---------------------------------------------------------------------------
  // Output regulated filter
  // ---------------------------------------------------------------------------
  smd_filter #(
    .FILT_CYC (FILTER_CYC)
  ) u_reg_filter (
    .clk       (clk),
    .rst_n     (rst_n),
    .level_in  (output_in_window),
    .level_out (regulated)
  );

  // ---------------------------------------------------------------------------
  // Status byte and decode
  // ---------------------------------------------------------------------------
  // Bit 6 is tied to zero; the rest reflect live flags.
  assign diag = {regulated, 1'b0, st.good_f, st.temp_f,
                 st.under_f, st.over_f, st.cmd_f, st.gfault_f};  // [RL7]

  // The supply reading only means something with the output up and gate supply good.
  assign meas_valid = output_enable & st.good_f;  // [RL3]

  // Command check: bad length, write to read-only or unmapped, read of unmapped.
  always_comb begin
    hit_rw   = (cmd_addr == SMD_ADDR_GATE_SETTING) || (cmd_addr == SMD_ADDR_OVER_THR) ||
               (cmd_addr == SMD_ADDR_UNDER_THR);
    hit_ro   = (cmd_addr == SMD_ADDR_SUPPLY_READ) || (cmd_addr == SMD_ADDR_TEMP_READ);
    hit_diag = (cmd_addr == SMD_ADDR_DIAG);
    cmd_bad  = !cmd_len_ok ||
               (!cmd_read && !(hit_rw || hit_diag)) ||
               (cmd_read && !(hit_rw || hit_ro || hit_diag));  // [RL10]
    do_write = cmd_valid && !cmd_read && !cmd_bad;
    case (cmd_addr)
      SMD_ADDR_GATE_SETTING: rd_val = st.gate_code;
      SMD_ADDR_OVER_THR:     rd_val = st.over_thr;
      SMD_ADDR_UNDER_THR:    rd_val = st.under_thr;
      SMD_ADDR_SUPPLY_READ:  rd_val = st.supply_rd;
      SMD_ADDR_TEMP_READ:    rd_val = st.temp_rd;  // [RL6]
      SMD_ADDR_DIAG:         rd_val = diag;
      default:               rd_val = 8'h00;
    endcase
  end

  // ---------------------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------------------
  // Flag vector order: under, over, cmd, temp, gate fault. A hardware set in
  // the same cycle as a software clear wins, so no event is lost. Off mode
  // clears unconditionally since nothing is monitored while off.
  always_comb begin
    next_st = st;
    set_v   = 5'h00;
    clr_v   = 5'h00;

    // Register writes; out-of-range gate codes are stored so that the
    // read-back can expose them.
    if (do_write) begin
      case (cmd_addr)
        SMD_ADDR_GATE_SETTING: next_st.gate_code = cmd_wdata;  // [RL1]
        SMD_ADDR_OVER_THR:     next_st.over_thr  = cmd_wdata;
        SMD_ADDR_UNDER_THR:    next_st.under_thr = cmd_wdata;
        default:               next_st.rsp = next_st.rsp;
      endcase
      if (hit_diag) begin
        clr_v = 5'h1F;  // [RL8]
      end
    end

    // Response data for the next frame: zero after a refused command.
    if (cmd_valid) begin
      next_st.first = 1'b0;
      if (cmd_bad) begin
        next_st.rsp = 8'h00;
        set_v[2]    = 1'b1;  // [RL10]
      end else if (cmd_read) begin
        next_st.rsp = rd_val;
      end else begin
        next_st.rsp = cmd_wdata;
      end
    end

    // Supply measurement and threshold checks.
    if (supply_sample_valid && meas_valid) begin
      next_st.supply_rd = supply_sample;  // [RL3]
      if (supply_sample < st.under_thr) begin
        set_v[0] = 1'b1;  // [RL4] [RL18]
      end
      if (supply_sample > st.over_thr) begin
        set_v[1] = 1'b1;  // [RL5] [RL18]
      end
    end

    // Temperature reading and overtemperature.
    if (temp_sample_valid) begin
      next_st.temp_rd = temp_sample;
    end
    if (temp_over_max) begin
      set_v[3] = 1'b1;  // [RL11]
    end

    // Gate supply sequencing.
    case (st.gst)
      SMD_GS_IDLE: begin
        next_st.cnt    = '0;
        next_st.good_f = 1'b0;
        if (output_enable && !st.fail) begin
          next_st.gst = SMD_GS_START;
        end
      end
      SMD_GS_START: begin
        next_st.cnt = st.cnt + 16'h0001;
        if (gate_supply_in_window && st.cnt >= GATE_STARTUP_CYC) begin
          next_st.good_f = 1'b1;  // [RL14]
          next_st.gst    = SMD_GS_RUN;
        end else if (st.cnt >= GATE_ERR_CYC) begin
          set_v[4]    = 1'b1;  // [RL13]
          next_st.gst = SMD_GS_IDLE;
        end
      end
      SMD_GS_RUN: begin
        if (!gate_supply_in_window) begin
          next_st.good_f = 1'b0;  // [RL14]
          next_st.fail   = 1'b1;
          next_st.gst    = SMD_GS_IDLE;
        end
      end
      default: begin
        next_st.gst = SMD_GS_IDLE;
      end
    endcase
    if (!output_enable) begin
      next_st.gst    = SMD_GS_IDLE;
      next_st.good_f = 1'b0;
    end

    // Sticky flags: set wins over a status write.
    flags_v = {st.gfault_f, st.temp_f, st.cmd_f, st.over_f, st.under_f};
    flags_v = (flags_v & ~clr_v) | set_v;
    next_st.under_f  = flags_v[0];
    next_st.over_f   = flags_v[1];
    next_st.cmd_f    = flags_v[2];
    next_st.temp_f   = flags_v[3];
    next_st.gfault_f = flags_v[4];

    // Fail-silent latch; clearing flags leaves it set.
    if (set_v[0] || set_v[1] || set_v[3] || set_v[4]) begin
      next_st.fail = 1'b1;  // [RL4] [RL5] [RL9] [RL11] [RL13] [RL17]
    end

    // Off mode releases the latch, clears flags and stops sequencing.
    if (off_mode) begin
      next_st.under_f  = 1'b0;  // [RL8]
      next_st.over_f   = 1'b0;
      next_st.cmd_f    = 1'b0;
      next_st.temp_f   = 1'b0;
      next_st.gfault_f = 1'b0;
      next_st.fail     = 1'b0;  // [RL17]
      next_st.good_f   = 1'b0;
      next_st.gst      = SMD_GS_IDLE;
      next_st.first    = 1'b1;
      next_st.rsp      = 8'h00;
    end
  end

  // Register the state; the first response after reset reads as zero.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      st           <= '0;
      st.gate_code <= SMD_RST_GATE_CODE;
      st.over_thr  <= SMD_RST_OVER_THR;
      st.under_thr <= SMD_RST_UNDER_THR;
      st.supply_rd <= SMD_RST_READING;
      st.temp_rd   <= SMD_RST_READING;
      st.first     <= 1'b1;
      st.gst       <= SMD_GS_IDLE;
    end else begin
      st <= next_st;
    end
  end

  // ---------------------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------------------
  // Status rides in the upper byte of every response frame except the first after reset or Off mode, which reads as zero.
  assign rsp_status         = st.first ? 8'h00 : diag;  // [RL16]
  assign rsp_data           = st.first ? 8'h00 : st.rsp;
  assign gate_supply_code   = st.gate_code;  // [RL1]
  assign gate_switch_enable = st.good_f & ~st.fail;  // [RL14]
  assign fail_silent        = st.fail;

  // ---------------------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------------------
  fail_latch_a : assert property (@(posedge clk) disable iff (!rst_n)  // [RL17]
    st.fail && !off_mode |=> st.fail)
    else $error("fail-silent released without Off mode");

  gate_switch_a : assert property (@(posedge clk) disable iff (!rst_n)  // [RL14]
    gate_switch_enable |-> st.good_f && !st.fail && st.gst == SMD_GS_RUN)
    else $error("gate switching allowed without good supply");

  under_detect_a : assert property (@(posedge clk) disable iff (!rst_n)  // [RL4]
    supply_sample_valid && meas_valid && supply_sample < st.under_thr && !off_mode
    |=> st.under_f && st.fail && !gate_switch_enable)
    else $error("undervoltage not flagged");

  over_detect_a : assert property (@(posedge clk) disable iff (!rst_n)  // [RL5]
    supply_sample_valid && meas_valid && supply_sample > st.over_thr && !off_mode
    |=> st.over_f && st.fail)
    else $error("overvoltage not flagged");

  meas_gate_a : assert property (@(posedge clk) disable iff (!rst_n)  // [RL18]
    !meas_valid && !st.under_f && !off_mode && !(cmd_valid && !cmd_read && hit_diag)
    |=> $stable(st.supply_rd) && !st.under_f)
    else $error("supply evaluated while measurement invalid");

  cmd_error_a : assert property (@(posedge clk) disable iff (!rst_n)  // [RL10]
    cmd_valid && !cmd_len_ok && !off_mode
    |=> st.cmd_f && rsp_data == 8'h00 && $stable(st.gate_code))
    else $error("bad command not flagged or not discarded");

  off_clear_a : assert property (@(posedge clk) disable iff (!rst_n)  // [RL8]
    off_mode |=> diag[4:0] == 5'h00 && !st.fail && rsp_status == 8'h00)
    else $error("Off mode did not clear the flags");

  diag_write_a : assert property (@(posedge clk) disable iff (!rst_n)  // [RL9]
    do_write && hit_diag && st.fail && !off_mode |=> st.fail)
    else $error("status write released fail-silent");

  temp_detect_a : assert property (@(posedge clk) disable iff (!rst_n)  // [RL11]
    temp_over_max && !off_mode |=> st.temp_f && st.fail)
    else $error("overtemperature not flagged");

  gate_fault_a : assert property (@(posedge clk) disable iff (!rst_n)  // [RL13]
    st.gst == SMD_GS_START && st.cnt >= GATE_ERR_CYC && !gate_supply_in_window
    && !off_mode && output_enable |=> st.gfault_f && st.fail)
    else $error("gate supply start-up error missed");

  reserved_zero_a : assert property (@(posedge clk) disable iff (!rst_n)  // [RL7]
    rsp_status[SMD_DG_RESERVED] == 1'b0 && (st.first || rsp_status[5] == st.good_f))
    else $error("status byte layout wrong");

endmodule

// >>> bench/smd_mcu.sv
// Microcontroller side model that issues decoded register commands to the monitor.
`timescale 1ns/10ps
module smd_mcu (
  input  wire logic                            clk,
  output logic                                 cmd_valid,
  output logic                                 cmd_read,
  output logic [smd_pkg::SMD_ADDR_W-1:0]       cmd_addr,
  output logic [smd_pkg::SMD_DATA_W-1:0]       cmd_wdata,
  output logic                                 cmd_len_ok
);
  import smd_pkg::*;

  // --------------------------------------------------------------------------
  // Command issue
  // --------------------------------------------------------------------------
  // Idle fields show the inverse of the last command, so a stale value is never mistaken.
  initial begin
    cmd_valid  = 1'b0;
    cmd_read   = 1'b0;
    cmd_addr   = 7'h00;
    cmd_wdata  = 8'h00;
    cmd_len_ok = 1'b0;
  end

  // One command pulse, then wait until the answer has landed in the response register.
  task automatic xfer(input logic rd, input logic [6:0] addr, input logic [7:0] wd,
                      input logic ok);
    @(posedge clk);
    cmd_valid  <= 1'b1;
    cmd_read   <= rd;
    cmd_addr   <= addr;
    cmd_wdata  <= wd;
    cmd_len_ok <= ok;
    @(posedge clk);
    cmd_valid  <= 1'b0;
    cmd_read   <= ~rd;
    cmd_addr   <= ~addr;
    cmd_wdata  <= ~wd;
    cmd_len_ok <= ~ok;
    @(posedge clk);
    #1;
  endtask

  // Writes the gate code and reads it back at once, leaving the read-back in the response.
  task automatic set_gate(input logic [7:0] code);
    xfer(1'b0, SMD_ADDR_GATE_SETTING, code, 1'b1);
    xfer(1'b1, SMD_ADDR_GATE_SETTING, 8'h00, 1'b1);
  endtask

  // Clears the sticky flags before software trusts the status byte.
  task automatic clear_diag();
    xfer(1'b0, SMD_ADDR_DIAG, 8'h00, 1'b1);
  endtask
endmodule

// >>> bench/tb.sv
// Self-checking testbench for the supply monitor and diagnostics block.
`timescale 1ns/10ps
module tb;
  import smd_pkg::*;

  // --------------------------------------------------------------------------
  // Signals and instances
  // --------------------------------------------------------------------------
  localparam logic [7:0] GOOD = 8'(1 << SMD_DG_GATE_GOOD);
  logic       clk, rst_n, off_mode, output_enable, gate_supply_in_window, output_in_window;
  logic       supply_sample_valid, temp_sample_valid, temp_over_max;
  logic [7:0] supply_sample, temp_sample;
  wire        cmd_valid, cmd_read, cmd_len_ok, gate_switch_enable, fail_silent;
  wire  [6:0] cmd_addr;
  wire  [7:0] cmd_wdata, rsp_status, rsp_data, gate_supply_code;
  int         mismatches  = 0;
  int         checks_done = 0;
  logic [6:0] ra [5] = '{7'h15, 7'h1A, 7'h1B, 7'h45, 7'h46};
  logic [7:0] rv [5] = '{8'h9A, 8'hFF, 8'h00, 8'h00, 8'h00};
  logic [6:0] ea [3] = '{7'h45, 7'h20, 7'h15};
  logic       er [3] = '{1'b0, 1'b1, 1'b0};
  logic       eo [3] = '{1'b1, 1'b1, 1'b0};

  smd_monitor #(.GATE_STARTUP_CYC(16'd20), .GATE_ERR_CYC(16'd60), .FILTER_CYC(16'd8))
  smd_monitor_i (.clk(clk), .rst_n(rst_n), .off_mode(off_mode),
    .output_enable(output_enable), .cmd_valid(cmd_valid), .cmd_read(cmd_read),
    .cmd_addr(cmd_addr), .cmd_wdata(cmd_wdata), .cmd_len_ok(cmd_len_ok),
    .rsp_status(rsp_status), .rsp_data(rsp_data),
    .supply_sample_valid(supply_sample_valid), .supply_sample(supply_sample),
    .temp_sample_valid(temp_sample_valid), .temp_sample(temp_sample),
    .temp_over_max(temp_over_max), .gate_supply_in_window(gate_supply_in_window),
    .output_in_window(output_in_window), .gate_supply_code(gate_supply_code),
    .gate_switch_enable(gate_switch_enable), .fail_silent(fail_silent));

  smd_mcu smd_mcu_i (.clk(clk), .cmd_valid(cmd_valid), .cmd_read(cmd_read),
    .cmd_addr(cmd_addr), .cmd_wdata(cmd_wdata), .cmd_len_ok(cmd_len_ok));

  // --------------------------------------------------------------------------
  // Helpers
  // --------------------------------------------------------------------------
  // Clock at 200 MHz.
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp) begin
      mismatches++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  // Kind 0 is a supply sample, 1 a temperature sample, 2 an overtemperature event.
  task automatic pulse(input int k, input logic [7:0] v);
    @(posedge clk);
    supply_sample       <= v;
    temp_sample         <= v;
    supply_sample_valid <= (k == 0);
    temp_sample_valid   <= (k == 1);
    temp_over_max       <= (k == 2);
    @(posedge clk);
    supply_sample_valid <= 1'b0;
    temp_sample_valid   <= 1'b0;
    temp_over_max       <= 1'b0;
    supply_sample       <= ~v;
    temp_sample         <= ~v;
    cyc(1);
  endtask

  // Passes through Off mode, then enables the output and lets the sequencer settle.
  task automatic restart(input logic win);
    @(posedge clk);
    output_enable         <= 1'b0;
    off_mode              <= 1'b1;
    gate_supply_in_window <= win;
    @(posedge clk);
    off_mode <= 1'b0;
    cyc(1);
    chk(rsp_data, 8'h00);
    chk({7'h00, fail_silent}, 8'h00);
    smd_mcu_i.xfer(1'b1, SMD_ADDR_DIAG, 8'h00, 1'b1);
    chk(rsp_status & 8'h1F, 8'h00);
    @(posedge clk);
    output_enable <= 1'b1;
    cyc(30);
  endtask

  task automatic print_verdict();
    $display("Checks done %0d, mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // The tests need well under 2000 cycles; a hang is cut short far beyond that.
  initial begin
    #50000;
    mismatches++;
    print_verdict();
  end

  // --------------------------------------------------------------------------
  // Tests
  // --------------------------------------------------------------------------
  initial begin
    rst_n = 1'b0;
    off_mode = 1'b0;
    output_enable = 1'b0;
    gate_supply_in_window = 1'b1;
    output_in_window = 1'b0;
    supply_sample_valid = 1'b0;
    temp_sample_valid = 1'b0;
    temp_over_max = 1'b0;
    supply_sample = 8'h00;
    temp_sample = 8'h00;
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    cyc(1);
    chk(rsp_data, 8'h00);
    chk(rsp_status, 8'h00);
    smd_mcu_i.xfer(1'b1, SMD_ADDR_DIAG, 8'h00, 1'b1);
    for (int i = 0; i < 5; i++) begin
      smd_mcu_i.xfer(1'b1, ra[i], 8'h00, 1'b1);
      chk(rsp_data, rv[i]);
    end
    // Both ends of the permitted gate range, then a mid code kept for later.
    foreach (rv[i]) begin
      smd_mcu_i.set_gate(i == 0 ? 8'h5D : (i == 1 ? 8'hB7 : 8'h80));
      chk(rsp_data, i == 0 ? 8'h5D : (i == 1 ? 8'hB7 : 8'h80));
      chk(gate_supply_code, i == 0 ? 8'h5D : (i == 1 ? 8'hB7 : 8'h80));
    end
    // Read-only write, reserved read and a short frame are all refused.
    for (int i = 0; i < 3; i++) begin
      smd_mcu_i.xfer(er[i], ea[i], 8'h11, eo[i]);
      chk(rsp_data, 8'h00);
      chk(rsp_status, 8'(1 << SMD_DG_CMD_ERR));
      chk(gate_supply_code, 8'h80);
    end
    smd_mcu_i.clear_diag();
    chk(rsp_status, 8'h00);
    // A sample while the output is disabled must be ignored.
    pulse(0, 8'h05);
    smd_mcu_i.xfer(1'b1, SMD_ADDR_SUPPLY_READ, 8'h00, 1'b1);
    chk(rsp_data, 8'h00);
    chk(rsp_status, 8'h00);
    smd_mcu_i.xfer(1'b0, SMD_ADDR_UNDER_THR, 8'h20, 1'b1);
    smd_mcu_i.xfer(1'b0, SMD_ADDR_OVER_THR, 8'hC0, 1'b1);
    @(posedge clk);
    output_enable <= 1'b1;
    cyc(10);
    chk({7'h00, gate_switch_enable}, 8'h00);
    cyc(20);
    chk(rsp_status, GOOD);
    chk({7'h00, gate_switch_enable}, 8'h01);
    pulse(0, 8'h80);
    smd_mcu_i.xfer(1'b1, SMD_ADDR_SUPPLY_READ, 8'h00, 1'b1);
    chk(rsp_data, 8'h80);
    pulse(0, 8'h20);
    pulse(0, 8'hC0);
    chk(rsp_status, GOOD);
    pulse(0, 8'h10);
    chk(rsp_status, GOOD | 8'(1 << SMD_DG_UNDER));
    chk({6'h00, fail_silent, gate_switch_enable}, 8'h02);
    smd_mcu_i.clear_diag();
    chk(rsp_status, GOOD);
    chk({7'h00, fail_silent}, 8'h01);
    restart(1'b1);
    pulse(0, 8'hD0);
    chk(rsp_status, GOOD | 8'(1 << SMD_DG_OVER));
    chk({6'h00, fail_silent, gate_switch_enable}, 8'h02);
    restart(1'b1);
    pulse(1, 8'h82);
    smd_mcu_i.xfer(1'b1, SMD_ADDR_TEMP_READ, 8'h00, 1'b1);
    chk(rsp_data, 8'h82);
    pulse(2, 8'h00);
    chk(rsp_status, GOOD | 8'(1 << SMD_DG_OVERTEMP));
    chk({7'h00, fail_silent}, 8'h01);
    // Window lost while running: good flag drops and the device goes silent.
    restart(1'b1);
    @(posedge clk);
    gate_supply_in_window <= 1'b0;
    cyc(3);
    chk(rsp_status & 8'h3F, 8'h00);
    chk({7'h00, fail_silent}, 8'h01);
    restart(1'b0);
    chk({7'h00, fail_silent}, 8'h00);
    cyc(40);
    chk(rsp_status & 8'h3F, 8'(1 << SMD_DG_GATE_FLT));
    chk({7'h00, fail_silent}, 8'h01);
    // The regulated flag follows the output window only after the filter time.
    restart(1'b1);
    @(posedge clk);
    output_in_window <= 1'b1;
    cyc(5);
    chk(rsp_status & 8'h80, 8'h00);
    cyc(9);
    chk(rsp_status & 8'h80, 8'h80);
    @(posedge clk);
    output_in_window <= 1'b0;
    cyc(5);
    chk(rsp_status & 8'h80, 8'h80);
    cyc(9);
    chk(rsp_status & 8'h80, 8'h00);
    print_verdict();
  end
endmodule
